// ===== common/tws_pkg.sv
// constants and types shared by the two-wire status and address block
`default_nettype none
package tws_pkg;
   // special-function register addresses
   localparam logic [7:0] SFR_SETUP = 8'hd2;
   localparam logic [7:0] SFR_STATUS = 8'hd8;
   localparam logic [7:0] SFR_DATA = 8'hd9;
   localparam logic [7:0] SFR_ADDR = 8'hda;
   // reset values
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   // status register bit positions
   localparam int ST_GC = 7;
   localparam int ST_STOP = 6;
   localparam int ST_IRQ = 5;
   localparam int ST_TX = 4;
   localparam int ST_BUSY = 3;
   localparam int ST_LOST = 2;
   localparam int ST_NACK = 1;
   localparam int ST_SLV = 0;
   // field positions in the setup and address registers
   localparam int SETUP_EN = 7;
   localparam int ADR_GC_EN = 0;
   // bit counter marks within one byte frame, and the general call address
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;
   localparam logic [6:0] GC_ADDR = 7'h00;
   // qualification count width in bits, and one sample clock
   localparam int QUAL_W = 8;
   localparam logic [7:0] ONE_SAMPLE = 8'h01;
   typedef enum logic [1:0] {
      LK_IDLE = 2'b00,
      LK_ADDR = 2'b01,
      LK_RX = 2'b10,
      LK_TX = 2'b11
   } tws_lk_state_t;
endpackage
`default_nettype wire

// ===== common/tws_qual_if.sv
// link-side signals between the bus engine and a condition qualifier
`default_nettype none
interface tws_qual_if;
   logic arm;
   logic hold;
   logic [tws_pkg::QUAL_W-1:0] need;
   logic fire;
   modport engine (output arm, output hold, output need, input fire);
   modport qual (input arm, input hold, input need, output fire);
endinterface
`default_nettype wire

// ===== tb/tws_bus_master_model.sv
// behavioural master on the two-wire bus, data line with pull-up
`default_nettype none
module tws_bus_master_model (
   // device side
   input wire logic dev_pull_in,
   // bus levels seen by the device
   output logic scl_out,
   output logic sda_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // third of a bit: longer than the 4-sample hold, shorter than the 12-sample one
   localparam int Q = 1600;
   logic m_low = 1'b0;
   initial scl_out = 1'b1;
   // open drain: either party pulling low wins
   assign sda_out = !(m_low || dev_pull_in);
   task automatic start_c;
      m_low = 1'b0;
      scl_out = 1'b1;
      #Q;
      m_low = 1'b1;
      #Q;
      scl_out = 1'b0;
      #Q;
   endtask
   task automatic stop_c;
      m_low = 1'b1;
      #Q;
      scl_out = 1'b1;
      #Q;
      m_low = 1'b0;
      #(2*Q);
   endtask
   // writing ff releases the line so the device can drive the byte
   task automatic xfer(input logic [7:0] b, output logic ack, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         m_low = !b[i];
         #Q;
         scl_out = 1'b1;
         #Q;
         rx[i] = sda_out;
         scl_out = 1'b0;
         #Q;
      end
      m_low = 1'b0;
      #Q;
      scl_out = 1'b1;
      #Q;
      ack = !sda_out;
      scl_out = 1'b0;
      #(2*Q);
   endtask
endmodule
`default_nettype wire

// ===== tb/tws_status_addr_tb.sv
// self-checking testbench for the two-wire status and address block
`default_nettype none
module tws_status_addr_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic lk_clk = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic irq;
   logic scl;
   logic sda;
   logic sda_drv;
   logic oe;
   logic ack;
   logic [7:0] got;
   logic [7:0] rx;
   logic mst = 1'b0;
   int fail_count = 0;
   int compares = 0;
   tws_status_addr u_tws_status_addr (
      .clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
      .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
      .ack_enable_in(1'b1), .mst_active_in(mst), .mst_tx_in(1'b0),
      .serial_irq_out(irq), .lk_clk_in(lk_clk), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_drv), .sda_oe_out(oe)
   );
   tws_bus_master_model u_tws_bus_master_model (
      .dev_pull_in(oe), .scl_out(scl), .sda_out(sda)
   );
   initial
   begin
      forever #20 clk_in = ~clk_in;
   end
   // phase offset keeps the sample clock unrelated to the system clock
   initial
   begin
      #7;
      forever #80 lk_clk = ~lk_clk;
   end
   task automatic results;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         fail_count++;
      end
   endtask
   // settings cross domains, so writes are spaced by 12 cycles
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
      repeat (12) @(negedge clk_in);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr = a;
      rd = 1'b1;
      @(negedge clk_in);
      rd = 1'b0;
      d = rdata;
   endtask
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 400)
      begin
         @(negedge clk_in);
         n++;
      end
      if (n == 400)
      begin
         fail_count++;
         results();
      end
   endtask
   task automatic t_regs;
      rd_reg(8'hd2, got);
      chk(got, tws_pkg::SETUP_RST);
      chk({5'h00, irq, sda_drv, oe}, 8'h00);
      wr_reg(tws_pkg::SFR_STATUS, 8'hff);
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h00);
      rd_reg(8'h55, got);
      chk(got, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_slave(input logic [7:0] setup);
      wr_reg(tws_pkg::SFR_SETUP, setup);
      rd_reg(tws_pkg::SFR_SETUP, got);
      chk(got, setup);
      wr_reg(tws_pkg::SFR_ADDR, 8'h54);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h54, ack, rx);
      chk({7'h00, ack}, 8'h01);
      u_tws_bus_master_model.xfer(8'hc5, ack, rx);
      chk({7'h00, ack}, 8'h01);
      wait_irq();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h29);
      rd_reg(tws_pkg::SFR_DATA, got);
      chk(got, 8'hc5);
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h09);
      u_tws_bus_master_model.stop_c();
      wait_irq();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h60);
      // the transmit byte must be in place before the address byte ends
      wr_reg(tws_pkg::SFR_DATA, 8'hc5);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h55, ack, rx);
      wait_irq();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h39);
      u_tws_bus_master_model.xfer(8'hff, ack, rx);
      chk(rx, 8'hc5);
      u_tws_bus_master_model.stop_c();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h62);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h20, ack, rx);
      chk({7'h00, ack}, 8'h00);
      u_tws_bus_master_model.stop_c();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk({6'h00, got[6:5]}, 8'h02);
      $display("test slave done for setup %h", setup);
   endtask
   // general call as slave, then a master byte that loses its first bit
   task automatic t_gc_lost;
      wr_reg(tws_pkg::SFR_ADDR, 8'h55);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h00, ack, rx);
      chk({7'h00, ack}, 8'h01);
      wait_irq();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'ha9);
      u_tws_bus_master_model.stop_c();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'he0);
      mst = 1'b1;
      wr_reg(tws_pkg::SFR_DATA, 8'hff);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h7f, ack, rx);
      wait_irq();
      rd_reg(tws_pkg::SFR_STATUS, got);
      chk(got, 8'h26);
      u_tws_bus_master_model.stop_c();
      @(negedge clk_in);
      mst = 1'b0;
      $display("test general call and arbitration done");
   endtask
   // a start held shorter than twelve samples must not open a transfer
   task automatic t_hold;
      wr_reg(tws_pkg::SFR_SETUP, 8'h8b);
      u_tws_bus_master_model.start_c();
      u_tws_bus_master_model.xfer(8'h54, ack, rx);
      chk({7'h00, ack}, 8'h00);
      u_tws_bus_master_model.stop_c();
      $display("test hold done");
   endtask
   initial
   begin
      // long enough for the reset to reach the sample clock domain
      repeat (16) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (20) @(negedge clk_in);
      t_regs();
      t_slave(8'h00);
      t_slave(8'h83);
      t_gc_lost();
      t_hold();
      results();
   end
   initial
   begin
      #3000000;
      fail_count++;
      results();
   end
endmodule
`default_nettype wire

// ===== verilog/tws_hold_qual.sv
// start or stop condition qualifier counting persistence in sample clocks
`default_nettype none
module tws_hold_qual (
   // link clock domain
   input wire logic clk_in,
   input wire logic rst_in,
   // condition handshake
   tws_qual_if.qual q
);
   logic [tws_pkg::QUAL_W-1:0] cnt_q;
   logic run_q;
   logic [tws_pkg::QUAL_W-1:0] cnt_nx;

   assign cnt_nx = cnt_q + tws_pkg::ONE_SAMPLE;

   // the edge sample itself counts as the first sample
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         run_q <= 1'b0;
         cnt_q <= '0;
      end
      else if (q.arm && q.hold)
      begin
         run_q <= (q.need > tws_pkg::ONE_SAMPLE);
         cnt_q <= tws_pkg::ONE_SAMPLE;
      end
      else if (run_q && q.hold)
      begin
         cnt_q <= cnt_nx;
         if (cnt_nx == q.need)
            run_q <= 1'b0;
      end
      else
         run_q <= 1'b0;
   end

   assign q.fire = (q.arm && q.hold && q.need == tws_pkg::ONE_SAMPLE) ||
                   (run_q && q.hold && !q.arm && cnt_nx == q.need);

   sequence armed4_s;
      q.arm && q.hold && q.need == 8'h04;
   endsequence
   sequence held3_s;
      (q.hold && !q.arm) [*3];
   endsequence

   single_sample_a: assert property (@(posedge clk_in) disable iff (rst_in)
      q.arm && q.hold && q.need == 8'h01 |-> q.fire)
      else $error("single sample did not qualify");
   persist_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
      armed4_s ##1 held3_s |-> q.fire && !$past(q.fire) && !$past(q.fire, 2) &&
         !$past(q.fire, 3))
      else $error("qualify count wrong");
endmodule
`default_nettype wire

// ===== verilog/tws_status_addr.sv
// two-wire status, data shift, own-address match and start/stop qualification
// Function
// - stop condition sets stop flag bit 6
// - interrupt flag bit 5, cleared by status read
// - bit 4 high while transmitting
// - bit 3 high while another master uses bus
// - bit 2 set on lost arbitration as master
// - bit 1 follows receiver acknowledge response
// - bit 0 high while acting as slave
// - own 7-bit address answered as slave
// - hold-time register at d2h, resets 00h
// - enable clear: one sample qualifies conditions
// - enable set: low bits plus one samples
// - status register is read-only dispatch vector
// - data shifts most significant bit first
// - general call acknowledged raises interrupt flag
`default_nettype none
module tws_status_addr (
   // system clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // special-function register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   // levels to and from the control logic
   input wire logic ack_enable_in,
   input wire logic mst_active_in,
   input wire logic mst_tx_in,
   output logic serial_irq_out,
   // bus side, sampled on the free-running sample clock
   input wire logic lk_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out
);
   localparam int LV_SLV = 0;
   localparam int LV_NACK = 1;
   localparam int LV_LOST = 2;
   localparam int LV_BUSY = 3;
   localparam int LV_TX = 4;
   localparam int EV_START = 0;
   localparam int EV_STOP = 1;
   localparam int EV_BYTE = 2;
   localparam tws_pkg::tws_lk_state_t LK_IDLE = tws_pkg::LK_IDLE;
   localparam tws_pkg::tws_lk_state_t LK_ADDR = tws_pkg::LK_ADDR;
   localparam tws_pkg::tws_lk_state_t LK_RX = tws_pkg::LK_RX;
   localparam tws_pkg::tws_lk_state_t LK_TX = tws_pkg::LK_TX;

   // system domain registers
   logic [7:0] setup_q;
   logic [7:0] data_q;
   logic [7:0] addr_q;
   logic irq_q;
   logic stop_q;
   logic gc_q;
   logic upd_tgl_q;
   logic [7:0] rdata_q;
   logic [7:0] status_v;
   logic [2:0] ev_m_q;
   logic [2:0] ev_s_q;
   logic [2:0] ev_p_q;
   logic [4:0] lv_m_q;
   logic [4:0] lv_s_q;
   logic [2:0] ev_hit;
   logic sta_rd;
   logic irq_set;

   // link domain registers
   logic lk_rst_m_q;
   logic lk_rst;
   logic [2:0] ctl_m_q;
   logic [2:0] ctl_s_q;
   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   logic upd_m_q;
   logic upd_s_q;
   logic upd_p_q;
   logic [7:0] hold_q;
   logic [6:0] own_q;
   logic gc_en_q;
   logic [7:0] setup_l_q;
   tws_pkg::tws_lk_state_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic drv_q;
   logic match_q;
   logic gc_hit_q;
   logic busy_q;
   logic lost_q;
   logic nack_q;
   logic slv_q;
   logic tx_q;
   logic [2:0] ev_tgl_q;
   logic [7:0] ev_byte_q;
   logic ev_addr_q;
   logic ev_gc_q;
   logic ev_slv_q;

   logic ack_en;
   logic mst;
   logic mst_tx;
   logic scl_rise;
   logic scl_fall;
   logic busy_st;
   logic ack_fall;
   logic end_fall;
   logic lose;
   logic hit;
   logic gc_hit;
   logic start_fire;
   logic stop_fire;

   tws_qual_if start_if ();
   tws_qual_if stop_if ();

   // ---------------- system domain ----------------
   assign sta_rd = sfr_rd_in && sfr_addr_in == tws_pkg::SFR_STATUS;
   assign ev_hit = ev_s_q ^ ev_p_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         ev_m_q <= '0;
         ev_s_q <= '0;
         ev_p_q <= '0;
         lv_m_q <= '0;
         lv_s_q <= '0;
      end
      else
      begin
         ev_m_q <= ev_tgl_q;
         ev_s_q <= ev_m_q;
         ev_p_q <= ev_s_q;
         lv_m_q <= {tx_q, busy_q, lost_q, nack_q, slv_q};
         lv_s_q <= lv_m_q;
      end
   end

   // writes to the status address fall through: it has no storage
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         setup_q <= tws_pkg::SETUP_RST;
         addr_q <= tws_pkg::ADDR_RST;
         upd_tgl_q <= 1'b0;
      end
      else if (sfr_wr_in)
      begin
         if (sfr_addr_in == tws_pkg::SFR_SETUP)
            setup_q <= sfr_wdata_in;
         if (sfr_addr_in == tws_pkg::SFR_ADDR)
            addr_q <= sfr_wdata_in;
         if (sfr_addr_in == tws_pkg::SFR_SETUP || sfr_addr_in == tws_pkg::SFR_ADDR ||
             sfr_addr_in == tws_pkg::SFR_DATA)
            upd_tgl_q <= !upd_tgl_q;
      end
   end

   // a software write wins over a received byte landing in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         data_q <= tws_pkg::DATA_RST;
      else if (sfr_wr_in && sfr_addr_in == tws_pkg::SFR_DATA)
         data_q <= sfr_wdata_in;
      else if (ev_hit[EV_BYTE])
         data_q <= ev_byte_q;
   end

   assign irq_set = ev_hit[EV_BYTE] || (ev_hit[EV_STOP] && ev_slv_q);

   // hardware set wins over the clear by a status read
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         irq_q <= 1'b0;
      else if (irq_set)
         irq_q <= 1'b1;
      else if (sta_rd)
         irq_q <= 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         stop_q <= 1'b0;
         gc_q <= 1'b0;
      end
      else
      begin
         if (ev_hit[EV_STOP])
            stop_q <= 1'b1;
         else if (ev_hit[EV_START])
            stop_q <= 1'b0;
         if (ev_hit[EV_BYTE] && ev_addr_q && ev_gc_q)
            gc_q <= 1'b1;
         else if (ev_hit[EV_START])
            gc_q <= 1'b0;
      end
   end

   always_comb
   begin
      status_v = '0;
      status_v[tws_pkg::ST_GC] = gc_q;
      status_v[tws_pkg::ST_STOP] = stop_q;
      status_v[tws_pkg::ST_IRQ] = irq_q;
      status_v[tws_pkg::ST_TX] = lv_s_q[LV_TX];
      status_v[tws_pkg::ST_BUSY] = lv_s_q[LV_BUSY];
      status_v[tws_pkg::ST_LOST] = lv_s_q[LV_LOST];
      status_v[tws_pkg::ST_NACK] = lv_s_q[LV_NACK];
      status_v[tws_pkg::ST_SLV] = lv_s_q[LV_SLV];
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in || !sfr_rd_in)
         rdata_q <= 8'h00;
      else
         unique case (sfr_addr_in)
            tws_pkg::SFR_SETUP: rdata_q <= setup_q;
            tws_pkg::SFR_STATUS: rdata_q <= status_v;
            tws_pkg::SFR_DATA: rdata_q <= data_q;
            tws_pkg::SFR_ADDR: rdata_q <= addr_q;
            default: rdata_q <= 8'h00;
         endcase
   end

   assign sfr_rdata_out = rdata_q;
   assign serial_irq_out = irq_q;

   // ---------------- link domain ----------------
   // reset and pins pass two flops before any logic reads them
   always_ff @(posedge lk_clk_in)
   begin
      lk_rst_m_q <= rst_in;
      lk_rst <= lk_rst_m_q;
   end

   always_ff @(posedge lk_clk_in)
   begin
      if (lk_rst)
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
         ctl_m_q <= '0;
         ctl_s_q <= '0;
         {upd_m_q, upd_s_q, upd_p_q} <= 3'h0;
      end
      else
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
         ctl_m_q <= {ack_enable_in, mst_active_in, mst_tx_in};
         ctl_s_q <= ctl_m_q;
         {upd_m_q, upd_s_q, upd_p_q} <= {upd_tgl_q, upd_m_q, upd_s_q};
      end
   end

   assign ack_en = ctl_s_q[2];
   assign mst = ctl_s_q[1];
   assign mst_tx = ctl_s_q[0];

   // settings are taken over only after the toggle has crossed, so the words are stable
   always_ff @(posedge lk_clk_in)
   begin
      if (lk_rst)
      begin
         hold_q <= tws_pkg::DATA_RST;
         own_q <= tws_pkg::ADDR_RST[7:1];
         gc_en_q <= 1'b0;
         setup_l_q <= tws_pkg::SETUP_RST;
      end
      else if (upd_s_q ^ upd_p_q)
      begin
         hold_q <= data_q;
         own_q <= addr_q[7:1];
         gc_en_q <= addr_q[tws_pkg::ADR_GC_EN];
         setup_l_q <= setup_q;
      end
   end

   assign start_if.arm = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign start_if.hold = scl_s_q && !sda_s_q;
   assign stop_if.arm = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign stop_if.hold = scl_s_q && sda_s_q;
   assign start_if.need = setup_l_q[tws_pkg::SETUP_EN] ?
      {1'b0, setup_l_q[6:0]} + tws_pkg::ONE_SAMPLE : tws_pkg::ONE_SAMPLE;
   assign stop_if.need = start_if.need;
   assign start_fire = start_if.fire;
   assign stop_fire = stop_if.fire;

   tws_hold_qual u_start_qual (
      .clk_in(lk_clk_in),
      .rst_in(lk_rst),
      .q(start_if.qual)
   );

   tws_hold_qual u_stop_qual (
      .clk_in(lk_clk_in),
      .rst_in(lk_rst),
      .q(stop_if.qual)
   );

   assign scl_rise = scl_s_q && !scl_p_q;
   assign scl_fall = !scl_s_q && scl_p_q;
   assign busy_st = st_q != LK_IDLE && !start_fire && !stop_fire;
   assign ack_fall = busy_st && scl_fall && cnt_q == tws_pkg::BIT_ACK;
   assign end_fall = busy_st && scl_fall && cnt_q == tws_pkg::BIT_END;
   assign lose = busy_st && scl_rise && st_q == LK_TX && mst && !lost_q &&
                 cnt_q < tws_pkg::BIT_ACK && sh_q[7] && !sda_s_q;
   assign gc_hit = gc_en_q && sh_q[7:1] == tws_pkg::GC_ADDR;
   assign hit = ack_en && (sh_q[7:1] == own_q || gc_hit);

   // byte engine: bits shift on rising clock, sda changes only on falling clock
   always_ff @(posedge lk_clk_in)
   begin
      if (lk_rst)
      begin
         st_q <= LK_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         drv_q <= 1'b0;
         match_q <= 1'b0;
         gc_hit_q <= 1'b0;
      end
      else if (start_fire)
      begin
         st_q <= mst ? LK_TX : LK_ADDR;
         cnt_q <= 4'h0;
         sh_q <= mst ? hold_q : sh_q;
         drv_q <= 1'b0;
         match_q <= 1'b0;
      end
      else if (stop_fire)
      begin
         st_q <= LK_IDLE;
         cnt_q <= 4'h0;
         drv_q <= 1'b0;
      end
      else if (busy_st && scl_rise)
      begin
         if (cnt_q < tws_pkg::BIT_ACK)
            sh_q <= {sh_q[6:0], sda_s_q};
         if (lose)
            drv_q <= 1'b0;
         cnt_q <= cnt_q + 4'h1;
      end
      else if (ack_fall)
      begin
         drv_q <= (st_q == LK_ADDR && hit) || (st_q == LK_RX && ack_en);
         match_q <= st_q == LK_ADDR && hit;
         gc_hit_q <= gc_hit;
      end
      else if (end_fall)
      begin
         cnt_q <= 4'h0;
         drv_q <= 1'b0;
         unique case (st_q)
            LK_ADDR:
               if (!match_q)
                  st_q <= LK_IDLE;
               else if (sh_q[0] && !gc_hit_q)
               begin
                  st_q <= LK_TX;
                  sh_q <= hold_q;
                  drv_q <= !hold_q[7];
               end
               else
                  st_q <= LK_RX;
            LK_TX:
               if (lost_q || (!mst && nack_q))
                  st_q <= LK_IDLE;
               else if (mst && !mst_tx)
                  st_q <= LK_RX;
               else
               begin
                  sh_q <= hold_q;
                  drv_q <= !hold_q[7];
               end
            default: st_q <= st_q;
         endcase
      end
      else if (busy_st && scl_fall && cnt_q < tws_pkg::BIT_ACK)
         drv_q <= st_q == LK_TX && !lost_q && !sh_q[7];
   end

   // role and condition levels reported in the status register
   always_ff @(posedge lk_clk_in)
   begin
      if (lk_rst)
      begin
         busy_q <= 1'b0;
         lost_q <= 1'b0;
         nack_q <= 1'b0;
         slv_q <= 1'b0;
         tx_q <= 1'b0;
      end
      else if (start_fire)
      begin
         busy_q <= !mst;
         lost_q <= 1'b0;
         slv_q <= 1'b0;
         tx_q <= mst;
      end
      else if (stop_fire)
      begin
         busy_q <= 1'b0;
         slv_q <= 1'b0;
         tx_q <= 1'b0;
      end
      else
      begin
         if (lose)
         begin
            lost_q <= 1'b1;
            tx_q <= 1'b0;
         end
         if (busy_st && scl_rise && cnt_q == tws_pkg::BIT_ACK)
            nack_q <= sda_s_q;
         if (end_fall && st_q == LK_ADDR && match_q)
         begin
            slv_q <= 1'b1;
            tx_q <= sh_q[0] && !gc_hit_q;
         end
         if (end_fall && st_q == LK_TX)
            tx_q <= mst ? mst_tx && !lost_q : !nack_q;
      end
   end

   // events cross as toggles; their data is held until the next one
   always_ff @(posedge lk_clk_in)
   begin
      if (lk_rst)
      begin
         ev_tgl_q <= '0;
         ev_byte_q <= 8'h00;
         ev_addr_q <= 1'b0;
         ev_gc_q <= 1'b0;
         ev_slv_q <= 1'b0;
      end
      else
      begin
         if (start_fire)
            ev_tgl_q[EV_START] <= !ev_tgl_q[EV_START];
         if (stop_fire)
         begin
            ev_tgl_q[EV_STOP] <= !ev_tgl_q[EV_STOP];
            ev_slv_q <= slv_q;
         end
         if (end_fall && (st_q != LK_ADDR || match_q))
         begin
            ev_tgl_q[EV_BYTE] <= !ev_tgl_q[EV_BYTE];
            ev_byte_q <= sh_q;
            ev_addr_q <= st_q == LK_ADDR;
            ev_gc_q <= gc_hit_q;
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = drv_q;

   sequence addr_ack_s;
      ack_fall && st_q == LK_ADDR && ack_en && sh_q[7:1] == own_q;
   endsequence

   stop_flag_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ev_hit[EV_STOP] |=> stop_q)
      else $error("stop flag not set");
   irq_read_clr_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sta_rd && !irq_set |=> !irq_q)
      else $error("interrupt flag not cleared by read");
   setup_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
      sfr_wr_in && sfr_addr_in == tws_pkg::SFR_SETUP |=> setup_q == $past(sfr_wdata_in))
      else $error("setup write lost");
   tx_mode_role_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      tx_q |-> slv_q || st_q == LK_TX || $past(mst))
      else $error("transmit flag without a role");
   busy_on_start_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      start_fire && !mst |=> busy_q ##1 busy_q)
      else $error("bus occupied flag missing");
   lost_master_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      $rose(lost_q) |-> $past(mst) && $past(st_q) == LK_TX && !drv_q)
      else $error("arbitration lost outside master transmit");
   nack_follow_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      busy_st && scl_rise && cnt_q == tws_pkg::BIT_ACK |=> nack_q == $past(sda_s_q))
      else $error("acknowledge response not captured");
   slave_match_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      addr_ack_s |=> drv_q && match_q)
      else $error("own address not acknowledged");
   msb_first_a: assert property (@(posedge lk_clk_in) disable iff (lk_rst)
      busy_st && scl_rise && cnt_q < tws_pkg::BIT_ACK |=>
         sh_q == {$past(sh_q[6:0]), $past(sda_s_q)})
      else $error("shift order wrong");
endmodule
`default_nettype wire
